/* File: hdl/txp_tx_path.sv */
// Dual-channel transmit converter path control, buffer to converter codes
`timescale 1ns/1ps
module txp_tx_path #(
  parameter int DEPTH = 32,
  parameter int DAC_MHZ = txp_pkg::CLK_MHZ,
  parameter int WAKE_CYCLES = txp_pkg::WAKE_CYC
)(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic tx_powerdown_pin,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [txp_pkg::DW-1:0] in_data_a,
  input wire logic [txp_pkg::DW-1:0] in_data_b,
  input wire logic cfg_load,
  input wire txp_pkg::txp_interp_t cfg_interp,
  input wire txp_pkg::txp_port_mode_t cfg_port_mode,
  input wire logic cfg_pll_en,
  input wire logic cfg_sleep,
  input wire logic [1:0] cfg_coarse_a,
  input wire logic [1:0] cfg_coarse_b,
  input wire logic [7:0] cfg_pga,
  input wire logic cfg_pga_fast,
  input wire logic [5:0] cfg_fine_a,
  input wire logic [5:0] cfg_fine_b,
  input wire logic [9:0] cfg_offset_a,
  input wire logic [9:0] cfg_offset_b,
  input wire logic cfg_offset_neg_a,
  input wire logic cfg_offset_neg_b,
  output logic [txp_pkg::DW-1:0] dac_code_a,
  output logic [txp_pkg::DW-1:0] dac_code_b,
  output logic dac_latch,
  output logic stage1_latch,
  output logic stage2_latch,
  output logic [2:0] pll_mult,
  output logic out_current_en,
  output logic analog_en,
  output logic bias_en,
  output logic path_ready,
  output logic underrun,
  output logic rate_fault,
  output logic pga_settling,
  output logic [1:0] coarse_a,
  output logic [1:0] coarse_b,
  output logic [7:0] pga_gain,
  output logic [5:0] fine_a,
  output logic [5:0] fine_b,
  output logic [9:0] ofs_pos_a,
  output logic [9:0] ofs_neg_a,
  output logic [9:0] ofs_pos_b,
  output logic [9:0] ofs_neg_b
);
  localparam int DW = txp_pkg::DW;
  typedef enum logic [1:0] {TXP_PD, TXP_WAKE, TXP_RUN} txp_pwr_t;

  // Pin synchroniser; only the second stage is read
  logic pd_s1_reg, pd_s2_reg;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pd_s1_reg <= 1'b1;
      pd_s2_reg <= 1'b1;
    end
    else
    begin
      pd_s1_reg <= tx_powerdown_pin;
      pd_s2_reg <= pd_s1_reg;
    end
  end

  // Configuration: loads are taken in every power state
  txp_pkg::txp_interp_t interp_reg, interp_next;
  txp_pkg::txp_port_mode_t mode_reg, mode_next;
  logic pll_reg, pll_next, sleep_reg, sleep_next, fast_reg, fast_next;
  logic [1:0] coa_reg, coa_next, cob_reg, cob_next;
  logic [7:0] pga_reg, pga_next;
  logic [5:0] fia_reg, fia_next, fib_reg, fib_next;
  logic [9:0] ofa_reg, ofa_next, ofb_reg, ofb_next;
  logic nga_reg, nga_next, ngb_reg, ngb_next;

  function automatic logic [1:0] coarse_ok(input logic [1:0] c,
    input logic [1:0] old);
    // Unused code is refused, setting kept
    coarse_ok = (c == txp_pkg::COARSE_X1 || c == txp_pkg::COARSE_HALF ||
      c == txp_pkg::COARSE_ELEVENTH) ? c : old;
  endfunction

  always_comb
  begin
    interp_next = interp_reg;
    mode_next = mode_reg;
    pll_next = pll_reg;
    sleep_next = sleep_reg;
    fast_next = fast_reg;
    coa_next = coa_reg;
    cob_next = cob_reg;
    pga_next = pga_reg;
    fia_next = fia_reg;
    fib_next = fib_reg;
    ofa_next = ofa_reg;
    ofb_next = ofb_reg;
    nga_next = nga_reg;
    ngb_next = ngb_reg;
    if (cfg_load)
    begin
      interp_next = (cfg_interp == txp_pkg::TXP_X1 ||
        cfg_interp == txp_pkg::TXP_X2 || cfg_interp == txp_pkg::TXP_X4) ?
        cfg_interp : interp_reg;
      mode_next = (cfg_port_mode == txp_pkg::TXP_FULL_DUPLEX_IL ||
        cfg_port_mode == txp_pkg::TXP_HALF_DUPLEX_IL ||
        cfg_port_mode == txp_pkg::TXP_HALF_DUPLEX_DUAL) ?
        cfg_port_mode : mode_reg;
      pll_next = cfg_pll_en;
      sleep_next = cfg_sleep;
      fast_next = cfg_pga_fast;
      coa_next = coarse_ok(cfg_coarse_a, coa_reg);
      cob_next = coarse_ok(cfg_coarse_b, cob_reg);
      pga_next = cfg_pga;
      fia_next = cfg_fine_a;
      fib_next = cfg_fine_b;
      ofa_next = cfg_offset_a;
      ofb_next = cfg_offset_b;
      nga_next = cfg_offset_neg_a;
      ngb_next = cfg_offset_neg_b;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      interp_reg <= txp_pkg::TXP_X1;
      mode_reg <= txp_pkg::TXP_FULL_DUPLEX_IL;
      pll_reg <= 1'b0;
      sleep_reg <= 1'b0;
      fast_reg <= 1'b0;
      coa_reg <= txp_pkg::COARSE_X1;
      cob_reg <= txp_pkg::COARSE_X1;
      pga_reg <= txp_pkg::PGA_RST;
      fia_reg <= txp_pkg::FINE_RST;
      fib_reg <= txp_pkg::FINE_RST;
      ofa_reg <= txp_pkg::OFFSET_RST;
      ofb_reg <= txp_pkg::OFFSET_RST;
      nga_reg <= 1'b0;
      ngb_reg <= 1'b0;
    end
    else
    begin
      interp_reg <= interp_next;
      mode_reg <= mode_next;
      pll_reg <= pll_next;
      sleep_reg <= sleep_next;
      fast_reg <= fast_next;
      coa_reg <= coa_next;
      cob_reg <= cob_next;
      pga_reg <= pga_next;
      fia_reg <= fia_next;
      fib_reg <= fib_next;
      ofa_reg <= ofa_next;
      ofb_reg <= ofb_next;
      nga_reg <= nga_next;
      ngb_reg <= ngb_next;
    end
  end

  // Power state: wake waits out power-down recovery before data flows
  txp_pwr_t pwr_reg, pwr_next;
  logic [$clog2(WAKE_CYCLES+1)-1:0] wk_reg, wk_next;
  always_comb
  begin
    pwr_next = pwr_reg;
    wk_next = wk_reg;
    unique case (pwr_reg)
      TXP_PD:
        if (!pd_s2_reg)
        begin
          pwr_next = TXP_WAKE;
          wk_next = '0;
        end
      TXP_WAKE:
        if (pd_s2_reg)
          pwr_next = TXP_PD;
        else if (wk_reg == ($bits(wk_reg))'(WAKE_CYCLES - 1))
          pwr_next = TXP_RUN;
        else
          wk_next = wk_reg + 1'b1;
      TXP_RUN:
        if (pd_s2_reg)
          pwr_next = TXP_PD;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pwr_reg <= TXP_PD;
      wk_reg <= '0;
    end
    else
    begin
      pwr_reg <= pwr_next;
      wk_reg <= wk_next;
    end
  end

  logic run;
  assign run = (pwr_reg == TXP_RUN);

  // Input pairing into the buffer; interleaved ports send A then B
  txp_stream_if #(.W(2*DW)) wr_s ();
  txp_stream_if #(.W(2*DW)) rd_s ();
  logic dual, hold_v_reg, hold_v_next;
  logic [DW-1:0] hold_reg, hold_next;
  assign dual = (mode_reg == txp_pkg::TXP_HALF_DUPLEX_DUAL);
  // Back-pressure from the buffer reaches the baseband
  assign in_ready = run & (wr_s.ready | (!dual & !hold_v_reg));
  assign wr_s.valid = run & in_valid & (dual | hold_v_reg);
  assign wr_s.data = dual ? {in_data_b, in_data_a} : {in_data_a, hold_reg};

  always_comb
  begin
    hold_next = hold_reg;
    hold_v_next = hold_v_reg;
    if (!run || dual)
      hold_v_next = 1'b0; // Half pair dropped on stop
    else if (in_valid && in_ready)
    begin
      hold_v_next = !hold_v_reg;
      if (!hold_v_reg)
        hold_next = in_data_a;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hold_reg <= '0;
      hold_v_reg <= 1'b0;
    end
    else
    begin
      hold_reg <= hold_next;
      hold_v_reg <= hold_v_next;
    end
  end

  txp_fifo #(.W(2*DW), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .wr(wr_s),
    .rd(rd_s)
  );

  // Phase of the update clock within one input period
  logic [1:0] ph_reg, ph_next, ph_last;
  logic take;
  always_comb
  begin
    unique case (interp_reg)
      txp_pkg::TXP_X2: ph_last = 2'h1;
      txp_pkg::TXP_X4: ph_last = 2'h3;
      default: ph_last = 2'h0;
    endcase
  end
  assign take = run & (ph_reg == ph_last);
  assign rd_s.ready = take;
  assign ph_next = !run ? 2'h0 : (ph_reg == ph_last) ? 2'h0 : ph_reg + 2'h1;

  // Sample history per channel: previous and current input samples
  logic [DW-1:0] pa_reg, pa_next, ca_reg, ca_next;
  logic [DW-1:0] pb_reg, pb_next, cb_reg, cb_next;
  logic und_reg, und_next;
  always_comb
  begin
    pa_next = pa_reg;
    ca_next = ca_reg;
    pb_next = pb_reg;
    cb_next = cb_reg;
    und_next = 1'b0;
    if (take)
    begin
      pa_next = ca_reg;
      pb_next = cb_reg;
      if (rd_s.valid)
      begin
        ca_next = rd_s.data[DW-1:0];
        cb_next = rd_s.data[2*DW-1:DW];
      end
      else
        und_next = 1'b1; // Buffer dry: last sample repeats
    end
  end

  // Two cascaded 2x stages; stage 2 bisects stage 1 output
  function automatic logic [DW-1:0] mid(input logic [DW-1:0] x,
    input logic [DW-1:0] y);
    logic [DW:0] s;
    s = {1'b0, x} + {1'b0, y};
    mid = s[DW:1];
  endfunction

  function automatic logic [DW-1:0] interp(input logic [DW-1:0] p,
    input logic [DW-1:0] c, input txp_pkg::txp_interp_t f,
    input logic [1:0] ph);
    logic [DW-1:0] m;
    m = mid(p, c); // Stage 1 sample
    interp = c;
    if (f == txp_pkg::TXP_X2)
      interp = (ph == 2'h0) ? m : c;
    else if (f == txp_pkg::TXP_X4)
      unique case (ph)
        2'h0: interp = mid(p, m);
        2'h1: interp = m;
        2'h2: interp = mid(m, c);
        default: interp = c;
      endcase
  endfunction

  logic [DW-1:0] da_next, db_next;
  assign da_next = run ? interp(pa_reg, ca_reg, interp_reg, ph_reg) :
    dac_code_a;
  assign db_next = run ? interp(pb_reg, cb_reg, interp_reg, ph_reg) :
    dac_code_b;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ph_reg <= 2'h0;
      pa_reg <= '0;
      ca_reg <= '0;
      pb_reg <= '0;
      cb_reg <= '0;
      und_reg <= 1'b0;
      dac_code_a <= '0;
      dac_code_b <= '0;
    end
    else
    begin
      ph_reg <= ph_next;
      pa_reg <= pa_next;
      ca_reg <= ca_next;
      pb_reg <= pb_next;
      cb_reg <= cb_next;
      und_reg <= und_next;
      dac_code_a <= da_next;
      dac_code_b <= db_next;
    end
  end
  assign underrun = und_reg;

  // Latch strobes only for stages that are enabled and clocked
  assign dac_latch = run;
  assign stage1_latch = run & (interp_reg != txp_pkg::TXP_X1) &
    ((interp_reg == txp_pkg::TXP_X2) | !ph_reg[0]);
  assign stage2_latch = run & (interp_reg == txp_pkg::TXP_X4);
  // Multiplier raises an input-rate clock by the factor
  always_comb
  begin
    pll_mult = txp_pkg::FACT_X1;
    if (pll_reg && interp_reg == txp_pkg::TXP_X2)
      pll_mult = txp_pkg::FACT_X2;
    else if (pll_reg && interp_reg == txp_pkg::TXP_X4)
      pll_mult = txp_pkg::FACT_X4;
  end

  // Rate check against the table, update clock taken as DAC_MHZ
  int lim_in, lim_out, fac;
  always_comb
  begin
    fac = 1;
    lim_in = txp_pkg::IL_X1_IN;
    lim_out = txp_pkg::IL_X1_OUT;
    if (interp_reg == txp_pkg::TXP_X2)
    begin
      fac = 2;
      lim_in = txp_pkg::X2_IN;
      lim_out = txp_pkg::X2_OUT;
    end
    else if (interp_reg == txp_pkg::TXP_X4)
    begin
      fac = 4;
      lim_in = txp_pkg::X4_IN;
      lim_out = txp_pkg::X4_OUT;
    end
    else if (dual)
    begin
      lim_in = txp_pkg::DUAL_X1_IN;
      lim_out = txp_pkg::DUAL_X1_OUT;
    end
  end
  assign rate_fault = (DAC_MHZ > lim_out) ||
    (DAC_MHZ > lim_in * fac);

  // Gain settling window after any new gain; fast mode halves it
  logic [$clog2(txp_pkg::PGA_SETTLE_CYC+1)-1:0] st_reg, st_next;
  always_comb
  begin
    st_next = (st_reg != '0) ? st_reg - 1'b1 : st_reg;
    if (pga_next != pga_reg)
      st_next = fast_next ? ($bits(st_reg))'(txp_pkg::PGA_FAST_CYC) :
        ($bits(st_reg))'(txp_pkg::PGA_SETTLE_CYC);
  end
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end
  assign pga_settling = (st_reg != '0);

  // Analog controls from power state and held settings
  assign bias_en = 1'b1;
  assign analog_en = (pwr_reg != TXP_PD);
  assign out_current_en = analog_en & !sleep_reg;
  assign path_ready = run;
  assign coarse_a = coa_reg;
  assign coarse_b = cob_reg;
  assign pga_gain = pga_reg;
  assign fine_a = fia_reg;
  assign fine_b = fib_reg;
  // Offset steered to one leg only, other leg zero
  assign ofs_pos_a = nga_reg ? txp_pkg::OFFSET_RST : ofa_reg;
  assign ofs_neg_a = nga_reg ? ofa_reg : txp_pkg::OFFSET_RST;
  assign ofs_pos_b = ngb_reg ? txp_pkg::OFFSET_RST : ofb_reg;
  assign ofs_neg_b = ngb_reg ? ofb_reg : txp_pkg::OFFSET_RST;
endmodule

/* File: include/txp_pkg.sv */
// Shared constants and types of the transmit converter path control
package txp_pkg;
  localparam int CLK_MHZ = 100;
  localparam int DW = 10;
  // Interpolation factor select
  typedef enum logic [1:0] {TXP_X1, TXP_X2, TXP_X4} txp_interp_t;
  // Input port arrangement
  typedef enum logic [1:0] {TXP_FULL_DUPLEX_IL, TXP_HALF_DUPLEX_IL,
    TXP_HALF_DUPLEX_DUAL} txp_port_mode_t;
  // Coarse gain codes: unity, one half, one eleventh
  localparam logic [1:0] COARSE_X1 = 2'h0;
  localparam logic [1:0] COARSE_HALF = 2'h1;
  localparam logic [1:0] COARSE_ELEVENTH = 2'h2;
  // Reset values
  localparam logic [7:0] PGA_RST = 8'h00;
  localparam logic [5:0] FINE_RST = 6'h00;
  localparam logic [9:0] OFFSET_RST = 10'h000;
  // Power-down recovery, longest time, rounded down
  localparam int WAKE_NS = 10000;
  localparam int WAKE_CYC = WAKE_NS * CLK_MHZ / 1000;
  // Gain stage settling; fast mode halves it
  localparam int PGA_SETTLE_NS = 2000;
  localparam int PGA_SETTLE_CYC = (PGA_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int PGA_FAST_CYC = PGA_SETTLE_CYC / 2;
  // Rate limits in MSPS
  localparam int IL_X1_IN = 80;
  localparam int IL_X1_OUT = 80;
  localparam int DUAL_X1_IN = 160;
  localparam int DUAL_X1_OUT = 160;
  localparam int X2_IN = 80;
  localparam int X2_OUT = 160;
  localparam int X4_IN = 50;
  localparam int X4_OUT = 200;
  // Factors
  localparam logic [2:0] FACT_X1 = 3'h1;
  localparam logic [2:0] FACT_X2 = 3'h2;
  localparam logic [2:0] FACT_X4 = 3'h4;
endpackage

/* File: include/txp_stream_if.sv */
// Valid/ready word carrier between the path and its sample buffer
`timescale 1ns/1ps
interface txp_stream_if #(parameter int W = 20);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: hdl/txp_fifo.sv */
// Sample buffer with valid/ready on both sides
`timescale 1ns/1ps
module txp_fifo #(
  parameter int W = 20,
  parameter int DEPTH = 32
)(
  input wire logic clk,
  input wire logic rst_b,
  txp_stream_if.snk wr,
  txp_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  // Honest full and empty from the occupancy count
  assign wr.ready = (cnt_reg != (AW+1)'(DEPTH));
  assign rd.valid = (cnt_reg != '0);
  assign rd.data = mem_reg[rp_reg];
  assign push = wr.valid & wr.ready;
  assign pop = rd.valid & rd.ready;

  // Pointer and count update
  always_comb
  begin
    wp_next = push ? wp_reg + 1'b1 : wp_reg;
    rp_next = pop ? rp_reg + 1'b1 : rp_reg;
    cnt_next = cnt_reg;
    if (push && !pop)
      cnt_next = cnt_reg + 1'b1;
    else if (pop && !push)
      cnt_next = cnt_reg - 1'b1;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage needs no reset; read only behind valid
  always_ff @(posedge clk)
  begin
    if (push)
      mem_reg[wp_reg] <= wr.data;
  end
endmodule

/* File: test/txp_tx_path_sva.sv */
// Concurrent checks on the transmit path control ports
`timescale 1ns/1ps
module txp_tx_path_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic tx_powerdown_pin,
  input wire logic in_ready,
  input wire logic cfg_load,
  input wire logic cfg_sleep,
  input wire logic [1:0] cfg_coarse_a,
  input wire logic [7:0] cfg_pga,
  input wire logic [5:0] cfg_fine_a,
  input wire logic [9:0] cfg_offset_a,
  input wire logic cfg_offset_neg_a,
  input wire logic dac_latch,
  input wire logic stage1_latch,
  input wire logic stage2_latch,
  input wire logic [2:0] pll_mult,
  input wire logic out_current_en,
  input wire logic analog_en,
  input wire logic bias_en,
  input wire logic path_ready,
  input wire logic [1:0] coarse_a,
  input wire logic [7:0] pga_gain,
  input wire logic [5:0] fine_a,
  input wire logic [9:0] ofs_pos_a,
  input wire logic [9:0] ofs_neg_a,
  input wire logic [9:0] ofs_pos_b,
  input wire logic [9:0] ofs_neg_b
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Load and x4 phase steps
  sequence s_load_ok;
    cfg_load && cfg_coarse_a != 2'h3;
  endsequence
  sequence s_x4_even;
    stage2_latch && stage1_latch;
  endsequence
  property p_coarse;
    s_load_ok |=> coarse_a == $past(cfg_coarse_a);
  endproperty
  property p_coarse_bad;
    cfg_load && cfg_coarse_a == 2'h3 |=> $stable(coarse_a);
  endproperty
  property p_pga;
    cfg_load |=> pga_gain == $past(cfg_pga);
  endproperty
  property p_fine;
    cfg_load |=> fine_a == $past(cfg_fine_a);
  endproperty
  property p_ofs_load;
    cfg_load |=> ($past(cfg_offset_neg_a) ? ofs_neg_a : ofs_pos_a)
      == $past(cfg_offset_a);
  endproperty
  property p_ofs_one_leg;
    (ofs_pos_a == 10'h000 || ofs_neg_a == 10'h000) &&
      (ofs_pos_b == 10'h000 || ofs_neg_b == 10'h000);
  endproperty
  property p_pd;
    tx_powerdown_pin [*4] |-> !analog_en && !dac_latch && bias_en;
  endproperty
  property p_pd_cfg;
    cfg_load && tx_powerdown_pin |=> pga_gain == $past(cfg_pga);
  endproperty
  property p_sleep;
    cfg_load && cfg_sleep |=> !out_current_en;
  endproperty
  property p_cur_analog;
    out_current_en |-> analog_en;
  endproperty
  property p_x4_alt;
    s_x4_even ##1 stage2_latch |-> !stage1_latch;
  endproperty
  property p_stage_dac;
    stage1_latch || stage2_latch |-> dac_latch;
  endproperty
  property p_x4_mult;
    stage2_latch && pll_mult != 3'h1 |-> pll_mult == 3'h4;
  endproperty
  property p_ready;
    in_ready |-> path_ready;
  endproperty
  a_coarse: assert property (p_coarse)
    else $error("coarse");
  a_coarse_bad: assert property (p_coarse_bad)
    else $error("cbad");
  a_pga: assert property (p_pga)
    else $error("pga");
  a_fine: assert property (p_fine)
    else $error("fine");
  a_ofs_load: assert property (p_ofs_load)
    else $error("ofs");
  a_ofs_one_leg: assert property (p_ofs_one_leg)
    else $error("leg");
  a_pd: assert property (p_pd)
    else $error("pd");
  a_pd_cfg: assert property (p_pd_cfg)
    else $error("pdcfg");
  a_sleep: assert property (p_sleep)
    else $error("sleep");
  a_cur_analog: assert property (p_cur_analog)
    else $error("cur");
  a_x4_alt: assert property (p_x4_alt)
    else $error("x4");
  a_stage_dac: assert property (p_stage_dac)
    else $error("stg");
  a_x4_mult: assert property (p_x4_mult)
    else $error("mult");
  a_ready: assert property (p_ready)
    else $error("rdy");
endmodule
bind txp_tx_path txp_tx_path_chk u_chk (.clk, .rst_b, .tx_powerdown_pin,
  .in_ready, .cfg_load, .cfg_sleep, .cfg_coarse_a, .cfg_pga, .cfg_fine_a,
  .cfg_offset_a, .cfg_offset_neg_a, .dac_latch, .stage1_latch, .stage2_latch,
  .pll_mult, .out_current_en, .analog_en, .bias_en, .path_ready, .coarse_a,
  .pga_gain, .fine_a, .ofs_pos_a, .ofs_neg_a, .ofs_pos_b, .ofs_neg_b);

/* File: test/txp_bb_model.sv */
// Baseband sample source feeding the transmit data port
`timescale 1ns/1ps
module txp_bb_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic go,
  input wire logic il,
  input wire logic [7:0] num,
  input wire logic in_ready,
  output logic in_valid,
  output logic [9:0] in_data_a,
  output logic [9:0] in_data_b
);
  logic [7:0] k_reg;
  logic half_reg;
  logic [9:0] junk_reg;
  logic [9:0] ramp;
  // Word k is (k mod 4)*256 on A, half of it on B; idle lines keep changing
  assign ramp = {k_reg[1:0], 8'h00};
  assign in_data_a = !in_valid ? junk_reg :
    (il && half_reg) ? ramp >> 1 : ramp;
  assign in_data_b = (in_valid && !il) ? ramp >> 1 : ~junk_reg;
  // Offer held until taken, A before B when interleaved
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      in_valid <= 1'b0;
      k_reg <= 8'h00;
      half_reg <= 1'b0;
      junk_reg <= 10'h2A5;
    end
    else
    begin
      junk_reg <= junk_reg + 10'h133;
      if (go)
      begin
        in_valid <= 1'b1;
        k_reg <= 8'h01;
        half_reg <= 1'b0;
      end
      else if (in_valid && in_ready)
      begin
        half_reg <= il && !half_reg;
        if (!il || half_reg)
        begin
          k_reg <= k_reg + 8'h01;
          in_valid <= k_reg != num;
        end
      end
    end
  end
endmodule

/* File: test/txp_tx_path_tb.sv */
// Self-checking bench of the transmit converter path control
`timescale 1ns/1ps
module txp_tx_path_tb;
  localparam int WK = 8;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic tx_powerdown_pin, in_valid, in_ready, cfg_load, cfg_pll_en, cfg_sleep;
  logic cfg_pga_fast, cfg_offset_neg_a, cfg_offset_neg_b, dac_latch, go, il;
  logic stage1_latch, stage2_latch, out_current_en, analog_en, bias_en;
  logic path_ready, underrun, rate_fault, pga_settling, full, urun;
  logic [9:0] in_data_a, in_data_b, cfg_offset_a, cfg_offset_b, dac_code_a;
  logic [9:0] dac_code_b, ofs_pos_a, ofs_neg_a, ofs_pos_b, ofs_neg_b, last;
  logic [7:0] cfg_pga, pga_gain, num;
  logic [5:0] cfg_fine_a, cfg_fine_b, fine_a, fine_b;
  logic [2:0] pll_mult;
  logic [1:0] cfg_coarse_a, cfg_coarse_b, coarse_a, coarse_b;
  txp_pkg::txp_interp_t cfg_interp;
  txp_pkg::txp_port_mode_t cfg_port_mode;
  int err_count = 0;
  int n_compared = 0;
  int i, cf, cs;
  logic [9:0] codes[$];
  always #5 clk = ~clk;
  txp_tx_path #(.WAKE_CYCLES(WK)) DUT (.clk, .rst_b, .tx_powerdown_pin,
    .in_valid, .in_ready, .in_data_a, .in_data_b, .cfg_load, .cfg_interp,
    .cfg_port_mode, .cfg_pll_en, .cfg_sleep, .cfg_coarse_a, .cfg_coarse_b,
    .cfg_pga, .cfg_pga_fast, .cfg_fine_a, .cfg_fine_b, .cfg_offset_a,
    .cfg_offset_b, .cfg_offset_neg_a, .cfg_offset_neg_b, .dac_code_a,
    .dac_code_b, .dac_latch, .stage1_latch, .stage2_latch, .pll_mult,
    .out_current_en, .analog_en, .bias_en, .path_ready, .underrun,
    .rate_fault, .pga_settling, .coarse_a, .coarse_b, .pga_gain, .fine_a,
    .fine_b, .ofs_pos_a, .ofs_neg_a, .ofs_pos_b, .ofs_neg_b);
  txp_bb_model BB (.clk, .rst_b, .go, .il, .num, .in_ready, .in_valid,
    .in_data_a, .in_data_b);
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // Inputs always move 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic load();
    cfg_load = 1'b1;
    tick(1);
    cfg_load = 1'b0;
    tick(1);
  endtask
  task automatic wait_run(output int n);
    n = 0;
    while (path_ready !== 1'b1 && n < 100)
    begin
      tick(1);
      n++;
    end
    if (n == 100)
    begin
      err_count++;
      complete_run();
    end
  endtask
  task automatic settle(output int n);
    n = 0;
    while (pga_settling === 1'b1 && n < 400)
    begin
      tick(1);
      n++;
    end
    if (n == 400)
    begin
      err_count++;
      complete_run();
    end
  endtask
  // Stream a ramp and compare distinct codes; underrun repeats are skipped
  task automatic run(input logic [1:0] f, input txp_pkg::txp_port_mode_t m,
    input logic [7:0] n, input int mult, input logic rf);
    rst_b = 1'b0;
    tick(16);
    rst_b = 1'b1;
    wait_run(i);
    cfg_interp = txp_pkg::txp_interp_t'(f);
    cfg_port_mode = m;
    load();
    chk(pll_mult, mult);
    chk(rate_fault, rf);
    il = m != txp_pkg::TXP_HALF_DUPLEX_DUAL;
    num = n;
    go = 1'b1;
    tick(1);
    go = 1'b0;
    codes = {};
    last = 10'h000;
    full = 1'b0;
    urun = 1'b0;
    for (i = 0; i < 900; i++)
    begin
      if (codes.size() >= 3 * mult && !in_valid && urun)
        break;
      if (dac_latch && dac_code_a != last && codes.size() < 3 * mult)
      begin
        codes.push_back(dac_code_a);
        chk(dac_code_b, dac_code_a >> 1);
        last = dac_code_a;
      end
      full = full | (in_valid & ~in_ready);
      urun = urun | underrun;
      tick(1);
    end
    if (i == 900)
    begin
      err_count++;
      complete_run();
    end
    for (i = 0; i < 3 * mult; i++)
      chk(codes[i], (i + 1) * (256 / mult));
    chk(full, n > 8'd40);
    chk(urun, 1'b1);
    $display("test stream x%0d done", mult);
  endtask
  initial
  begin
    {tx_powerdown_pin, cfg_load, cfg_sleep, go, il} = 5'h00;
    {cfg_offset_neg_a, cfg_offset_neg_b, cfg_pga_fast} = 3'h0;
    cfg_pll_en = 1'b1;
    num = 8'h03;
    cfg_interp = txp_pkg::TXP_X1;
    cfg_port_mode = txp_pkg::TXP_HALF_DUPLEX_DUAL;
    {cfg_coarse_a, cfg_coarse_b, cfg_pga, cfg_fine_a, cfg_fine_b} = 24'h0;
    {cfg_offset_a, cfg_offset_b} = 20'h0;
    tick(3);
    chk({coarse_a, coarse_b, pga_gain, fine_a, fine_b}, 0);
    chk({bias_en, analog_en, out_current_en}, 3'h4);
    tick(13);
    rst_b = 1'b1;
    wait_run(i);
    // Settings load, steering and refused coarse code
    cfg_coarse_a = txp_pkg::COARSE_HALF;
    cfg_coarse_b = txp_pkg::COARSE_ELEVENTH;
    cfg_pga = 8'h5A;
    cfg_pga_fast = 1'b1;
    {cfg_fine_a, cfg_fine_b} = 12'hA95;
    {cfg_offset_a, cfg_offset_b} = {10'h3FF, 10'h155};
    cfg_offset_neg_a = 1'b1;
    load();
    chk({coarse_a, coarse_b}, 4'h6);
    chk(pga_gain, 8'h5A);
    chk({fine_a, fine_b}, 12'hA95);
    chk({ofs_pos_a, ofs_neg_a}, {10'h000, 10'h3FF});
    chk({ofs_pos_b, ofs_neg_b}, {10'h155, 10'h000});
    settle(cf);
    cfg_coarse_a = 2'h3;
    cfg_pga = 8'h10;
    cfg_pga_fast = 1'b0;
    load();
    chk(coarse_a, txp_pkg::COARSE_HALF);
    settle(cs);
    // Window opens at the load edge; counting starts one cycle later
    chk(cf, txp_pkg::PGA_FAST_CYC - 1);
    chk(cs, txp_pkg::PGA_SETTLE_CYC - 1);
    $display("test config done");
    cfg_sleep = 1'b1;
    load();
    chk({out_current_en, analog_en, dac_latch}, 3'h3);
    cfg_sleep = 1'b0;
    load();
    chk(out_current_en, 1'b1);
    $display("test sleep done");
    // Pin power-down keeps biases and still takes settings
    tx_powerdown_pin = 1'b1;
    tick(4);
    chk({analog_en, bias_en, dac_latch, in_ready}, 4'h4);
    cfg_coarse_a = txp_pkg::COARSE_ELEVENTH;
    load();
    chk(coarse_a, txp_pkg::COARSE_ELEVENTH);
    tx_powerdown_pin = 1'b0;
    wait_run(i);
    chk(i >= WK, 1);
    $display("test powerdown done");
    run(2'h0, txp_pkg::TXP_FULL_DUPLEX_IL, 8'h03, 1, 1'b1);
    run(2'h1, txp_pkg::TXP_HALF_DUPLEX_IL, 8'h03, 2, 1'b0);
    run(2'h2, txp_pkg::TXP_HALF_DUPLEX_DUAL, 8'h3C, 4, 1'b0);
    complete_run();
  end
endmodule
